// *** inc/dspcv_pkg.sv ***
package dspcv_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction field positions
  localparam int unsigned MAJOR_LSB = 26;
  localparam int unsigned FIRST_LSB = 21;
  localparam int unsigned SECOND_LSB = 16;
  localparam int unsigned DEST_LSB = 11;
  localparam int unsigned SUB_LSB = 6;
  localparam int unsigned FUNC_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode values
  localparam logic [5:0] EXTENSION_MAJOR_OPCODE = 6'h1F;
  localparam logic [5:0] COMPARE_GROUP_FUNCTION = 6'h11;
  localparam logic [5:0] ABSOLUTE_GROUP_FUNCTION = 6'h12;
  localparam logic [4:0] SUB_EXPAND_RIGHT_ALT = 5'h1F;
  localparam logic [4:0] SUB_TRUNC_HALVES = 5'h14;
  localparam logic [4:0] SUB_TRUNC_BYTES = 5'h0C;
  localparam logic [4:0] SUB_ROUND_HALVES = 5'h15;
  localparam logic [4:0] SUB_SAT_UBYTES = 5'h0F;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic constants and flag position
  localparam logic [32:0] ROUND_ADDEND = 33'h0_0000_8000;
  localparam logic [15:0] HALF_SAT_MAX = 16'h7FFF;
  localparam logic [15:0] UBYTE_LIMIT = 16'h7F80;
  localparam logic [7:0] UBYTE_MAX = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int unsigned OUFLAG_SAT_BIT = 22;
  localparam logic [31:0] OUFLAG_SAT_MASK = 32'h0040_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [4:0] RST_REG_IDX = 5'h00;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_EXPAND_RIGHT_ALT,
    OP_TRUNC_HALVES,
    OP_TRUNC_BYTES,
    OP_ROUND_HALVES,
    OP_SAT_UBYTES
  } dspcv_op_t;

endpackage

// *** hw/dspcv_decode.sv ***
module dspcv_decode (
  input wire logic [31:0] i_instr,
  output dspcv_pkg::dspcv_op_t o_op
);
  import dspcv_pkg::*;

  wire [5:0] major_w = i_instr[MAJOR_LSB +: 6];
  wire [4:0] sub_w = i_instr[SUB_LSB +: 5];
  wire [5:0] func_w = i_instr[FUNC_LSB +: 6];
  wire ext_w = (major_w == EXTENSION_MAJOR_OPCODE);
  wire cmp_grp_w = ext_w & (func_w == COMPARE_GROUP_FUNCTION);
  wire abs_grp_w = ext_w & (func_w == ABSOLUTE_GROUP_FUNCTION);

  // Pure opcode decode; operand values never take part
  assign o_op = (abs_grp_w && sub_w == SUB_EXPAND_RIGHT_ALT) ? OP_EXPAND_RIGHT_ALT :
                (cmp_grp_w && sub_w == SUB_TRUNC_HALVES) ? OP_TRUNC_HALVES :
                (cmp_grp_w && sub_w == SUB_TRUNC_BYTES) ? OP_TRUNC_BYTES :
                (cmp_grp_w && sub_w == SUB_ROUND_HALVES) ? OP_ROUND_HALVES :
                (cmp_grp_w && sub_w == SUB_SAT_UBYTES) ? OP_SAT_UBYTES :
                OP_NONE;

endmodule // dspcv_decode

// *** hw/dspcv_sat_lanes.sv ***
module dspcv_sat_lanes (
  input wire logic [31:0] i_first,
  input wire logic [31:0] i_second,
  output logic [31:0] o_round_word,
  output logic o_round_ovf,
  output logic [31:0] o_ubyte_word,
  output logic o_ubyte_clamp
);
  import dspcv_pkg::*;

  // Returns {overflow, halfword}
  function automatic logic [16:0] round_half(input logic [31:0] v);
    logic [32:0] sum;
    sum = {v[31], v} + ROUND_ADDEND;
    if (sum[32] != sum[31]) begin
      return {1'b1, HALF_SAT_MAX};
    end
    return {1'b0, sum[31:16]};
  endfunction

  // Returns {clamped, byte}; negative wins over the upper clamp
  function automatic logic [8:0] ubyte(input logic [15:0] h);
    if (h[15]) begin
      return {1'b1, BYTE_ZERO};
    end else if (h > UBYTE_LIMIT) begin
      return {1'b1, UBYTE_MAX};
    end
    return {1'b0, h[14:7]};
  endfunction

  wire [16:0] rnd_a_w = round_half(i_first);
  wire [16:0] rnd_b_w = round_half(i_second);
  wire [8:0] ub_a_w = ubyte(i_first[31:16]);
  wire [8:0] ub_b_w = ubyte(i_first[15:0]);
  wire [8:0] ub_c_w = ubyte(i_second[31:16]);
  wire [8:0] ub_d_w = ubyte(i_second[15:0]);

  assign o_round_word = {rnd_a_w[15:0], rnd_b_w[15:0]};
  assign o_round_ovf = rnd_a_w[16] | rnd_b_w[16];
  assign o_ubyte_word = {ub_a_w[7:0], ub_b_w[7:0], ub_c_w[7:0], ub_d_w[7:0]};
  assign o_ubyte_clamp = ub_a_w[8] | ub_b_w[8] | ub_c_w[8] | ub_d_w[8];

endmodule // dspcv_sat_lanes

// *** hw/dspcv_unit.sv ***
module dspcv_unit (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_issue_valid,
  input wire logic [31:0] i_instr,
  input wire logic [31:0] i_first_src,
  input wire logic [31:0] i_second_src,
  input wire logic [31:0] i_dsp_control,
  output logic o_result_valid,
  output logic [31:0] o_result,
  output logic [4:0] o_dest_idx,
  output logic o_ctrl_we,
  output logic [31:0] o_ctrl_value,
  output logic o_unknown
);
  import dspcv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and lanes

  dspcv_pkg::dspcv_op_t op_w;
  logic [31:0] round_word_w;
  logic round_ovf_w;
  logic [31:0] ubyte_word_w;
  logic ubyte_clamp_w;

  dspcv_decode u_decode (
    .i_instr(i_instr),
    .o_op(op_w)
  );

  dspcv_sat_lanes u_lanes (
    .i_first(i_first_src),
    .i_second(i_second_src),
    .o_round_word(round_word_w),
    .o_round_ovf(round_ovf_w),
    .o_ubyte_word(ubyte_word_w),
    .o_ubyte_clamp(ubyte_clamp_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result selection

  wire issue_ok_w = i_issue_valid & (op_w != OP_NONE);
  // Unknown depends on the opcode and i_issue_valid only, never on operand values
  wire unknown_w = i_issue_valid & (op_w == OP_NONE);
  wire [31:0] expand_w = {BYTE_ZERO, i_second_src[23:16], BYTE_ZERO, i_second_src[7:0]};
  wire [31:0] trunc_half_w = {i_first_src[31:16], i_second_src[31:16]};
  wire [31:0] trunc_byte_w = {i_first_src[31:24], i_first_src[15:8],
                              i_second_src[31:24], i_second_src[15:8]};
  wire sat_event_w = ((op_w == OP_ROUND_HALVES) & round_ovf_w) |
                     ((op_w == OP_SAT_UBYTES) & ubyte_clamp_w);

  logic [31:0] result_next;
  always_comb begin
    case (op_w)
      OP_EXPAND_RIGHT_ALT: result_next = expand_w;
      OP_TRUNC_HALVES: result_next = trunc_half_w;
      OP_TRUNC_BYTES: result_next = trunc_byte_w;
      OP_ROUND_HALVES: result_next = round_word_w;
      OP_SAT_UBYTES: result_next = ubyte_word_w;
      default: result_next = RST_WORD;
    endcase
  end

  // Only bit 22 is forced high; a write never clears anything. The caller must
  // forward a pending control write into i_dsp_control for back-to-back issues.
  wire [31:0] ctrl_value_next = i_dsp_control | OUFLAG_SAT_MASK;
  wire ctrl_we_next = issue_ok_w & sat_event_w;

  ////////////////////////////////////////////////////////////////////////////
  // Output registers: result and flag leave in the same cycle

  logic result_valid_reg;
  logic [31:0] result_reg;
  logic [4:0] dest_idx_reg;
  logic ctrl_we_reg;
  logic [31:0] ctrl_value_reg;
  logic unknown_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      result_valid_reg <= 1'b0;
      result_reg <= RST_WORD;
      dest_idx_reg <= RST_REG_IDX;
      ctrl_we_reg <= 1'b0;
      ctrl_value_reg <= RST_WORD;
      unknown_reg <= 1'b0;
    end else begin
      result_valid_reg <= issue_ok_w;
      result_reg <= result_next;
      dest_idx_reg <= i_instr[DEST_LSB +: 5];
      ctrl_we_reg <= ctrl_we_next;
      ctrl_value_reg <= ctrl_value_next;
      unknown_reg <= unknown_w;
    end
  end

  assign o_result_valid = result_valid_reg;
  assign o_result = result_reg;
  assign o_dest_idx = dest_idx_reg;
  assign o_ctrl_we = ctrl_we_reg;
  assign o_ctrl_value = ctrl_value_reg;
  assign o_unknown = unknown_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  // Reference rounding sum for the second lane, read only by checks
  wire [32:0] ref_sum_w = {i_second_src[31], i_second_src} + ROUND_ADDEND;
  wire is_exp_w = issue_ok_w & (op_w == OP_EXPAND_RIGHT_ALT);
  wire is_trh_w = issue_ok_w & (op_w == OP_TRUNC_HALVES);
  wire is_trb_w = issue_ok_w & (op_w == OP_TRUNC_BYTES);
  wire is_rnd_w = issue_ok_w & (op_w == OP_ROUND_HALVES);
  wire is_sat_w = issue_ok_w & (op_w == OP_SAT_UBYTES);

  property p_expand_lanes;
    is_exp_w |=> o_result[23:16] == $past(i_second_src[23:16]) && o_result[7:0] == $past(i_second_src[7:0]);
  endproperty
  a_expand_lanes: assert property (p_expand_lanes) else $error("expand lanes wrong");

  property p_expand_zero;
    is_exp_w |=> o_result_valid && o_result[31:24] == 8'h00 && o_result[15:8] == 8'h00;
  endproperty
  a_expand_zero: assert property (p_expand_zero) else $error("expand not zero-extended");

  property p_no_data_fault;
    issue_ok_w |=> !o_unknown && o_result_valid;
  endproperty
  a_no_data_fault: assert property (p_no_data_fault) else $error("known op flagged");

  property p_trunc_halves;
    is_trh_w |=> o_result == {$past(i_first_src[31:16]), $past(i_second_src[31:16])};
  endproperty
  a_trunc_halves: assert property (p_trunc_halves) else $error("word truncate wrong");

  property p_decode_trunc_halves;
    i_instr[31:26] == 6'h1F && i_instr[10:6] == 5'h14 && i_instr[5:0] == 6'h11 |-> op_w == OP_TRUNC_HALVES;
  endproperty
  a_decode_trunc_halves: assert property (p_decode_trunc_halves) else $error("decode word truncate");

  property p_dest_field;
    i_issue_valid |=> o_dest_idx == $past(i_instr[15:11]);
  endproperty
  a_dest_field: assert property (p_dest_field) else $error("destination field");

  property p_trunc_bytes;
    is_trb_w |=> o_result == {$past(i_first_src[31:24]), $past(i_first_src[15:8]),
                              $past(i_second_src[31:24]), $past(i_second_src[15:8])};
  endproperty
  a_trunc_bytes: assert property (p_trunc_bytes) else $error("byte truncate wrong");

  property p_decode_trunc_bytes;
    i_instr[31:26] == 6'h1F && i_instr[10:6] == 5'h0C && i_instr[5:0] == 6'h11 |-> op_w == OP_TRUNC_BYTES;
  endproperty
  a_decode_trunc_bytes: assert property (p_decode_trunc_bytes) else $error("decode byte truncate");

  property p_round_sum;
    is_rnd_w |=> o_result[15:0] == ($past(ref_sum_w[32]) != $past(ref_sum_w[31]) ? 16'h7FFF
                                     : $past(ref_sum_w[31:16]));
  endproperty
  a_round_sum: assert property (p_round_sum) else $error("rounding lane wrong");

  property p_round_sat;
    is_rnd_w && !i_first_src[31] && i_first_src[30:15] == 16'hFFFF |=> o_result[31:16] == 16'h7FFF;
  endproperty
  a_round_sat: assert property (p_round_sat) else $error("rounding not saturated");

  property p_round_plain;
    is_rnd_w && !(!i_first_src[31] && i_first_src[30:15] == 16'hFFFF)
      |=> o_result[31:16] == 16'($past(i_first_src[31:16]) + 16'($past(i_first_src[15])));
  endproperty
  a_round_plain: assert property (p_round_plain) else $error("rounded upper half wrong");

  property p_round_flag;
    is_rnd_w && (ref_sum_w[32] != ref_sum_w[31]) |=> o_ctrl_we && o_ctrl_value[22];
  endproperty
  a_round_flag: assert property (p_round_flag) else $error("rounding flag missing");

  property p_sat_neg;
    is_sat_w && i_first_src[31] |=> o_result[31:24] == 8'h00;
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("negative not zero");

  property p_sat_mid;
    is_sat_w && !i_first_src[15] && i_first_src[15:0] <= 16'h7F80 |=> o_result[23:16] == $past(i_first_src[14:7]);
  endproperty
  a_sat_mid: assert property (p_sat_mid) else $error("in-range byte wrong");

  property p_sat_high;
    is_sat_w && !i_second_src[31] && i_second_src[31:16] > 16'h7F80 |=> o_result[15:8] == 8'hFF;
  endproperty
  a_sat_high: assert property (p_sat_high) else $error("upper clamp wrong");

  property p_sat_order;
    is_sat_w && !ubyte_clamp_w |=> o_result == {$past(i_first_src[30:23]), $past(i_first_src[14:7]),
                                                $past(i_second_src[30:23]), $past(i_second_src[14:7])};
  endproperty
  a_sat_order: assert property (p_sat_order) else $error("byte order wrong");

  property p_sat_neg_flag;
    is_sat_w && (i_first_src[31] | i_first_src[15] | i_second_src[31] | i_second_src[15])
      |=> o_ctrl_we && o_ctrl_value[22];
  endproperty
  a_sat_neg_flag: assert property (p_sat_neg_flag) else $error("negative clamp flag");

  property p_sat_high_flag;
    is_sat_w && !i_second_src[15] && i_second_src[15:0] > 16'h7F80 |=> o_ctrl_we && o_ctrl_value[22];
  endproperty
  a_sat_high_flag: assert property (p_sat_high_flag) else $error("upper clamp flag");

  property p_decode_expand;
    i_instr[31:26] == 6'h1F && i_instr[10:6] == 5'h1F && i_instr[5:0] == 6'h12 |-> op_w == OP_EXPAND_RIGHT_ALT;
  endproperty
  a_decode_expand: assert property (p_decode_expand) else $error("decode expand");

  property p_flag_keep;
    o_ctrl_we |-> o_ctrl_value == ($past(i_dsp_control) | 32'h0040_0000);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("control bits disturbed");

  property p_no_flag_quiet;
    (is_exp_w || is_trh_w || is_trb_w || !i_issue_valid) |=> !o_ctrl_we;
  endproperty
  a_no_flag_quiet: assert property (p_no_flag_quiet) else $error("spurious flag write");

  property p_commit_together;
    o_ctrl_we |-> o_result_valid && $past(issue_ok_w);
  endproperty
  a_commit_together: assert property (p_commit_together) else $error("flag without result");

  property p_unknown_quiet;
    o_unknown |-> !o_result_valid && !o_ctrl_we;
  endproperty
  a_unknown_quiet: assert property (p_unknown_quiet) else $error("unknown op wrote back");

  property p_foreign_major;
    i_issue_valid && i_instr[31:26] != 6'h1F |=> o_unknown && !o_result_valid;
  endproperty
  a_foreign_major: assert property (p_foreign_major) else $error("foreign opcode accepted");

  property p_idle_quiet;
    !i_issue_valid |=> !o_result_valid && !o_unknown;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("output without issue");

  property p_flag_source;
    o_ctrl_we |-> $past(is_rnd_w || is_sat_w);
  endproperty
  a_flag_source: assert property (p_flag_source) else $error("flag from non-saturating op");

  property p_round_flag_first;
    is_rnd_w && !i_first_src[31] && i_first_src[30:15] == 16'hFFFF |=> o_ctrl_we && o_ctrl_value[22];
  endproperty
  a_round_flag_first: assert property (p_round_flag_first) else $error("first lane flag missing");

  property p_round_no_flag;
    is_rnd_w && ref_sum_w[32] == ref_sum_w[31] && !(!i_first_src[31] && i_first_src[30:15] == 16'hFFFF)
      |=> !o_ctrl_we;
  endproperty
  a_round_no_flag: assert property (p_round_no_flag) else $error("rounding flag without overflow");

  property p_sat_neg_low;
    is_sat_w && i_second_src[15] |=> o_result[7:0] == 8'h00;
  endproperty
  a_sat_neg_low: assert property (p_sat_neg_low) else $error("low negative not zero");

  property p_sat_mid_low;
    is_sat_w && !i_second_src[15] && i_second_src[15:0] <= 16'h7F80
      |=> o_result[7:0] == $past(i_second_src[14:7]);
  endproperty
  a_sat_mid_low: assert property (p_sat_mid_low) else $error("low in-range byte wrong");

  property p_sat_high_first;
    is_sat_w && !i_first_src[31] && i_first_src[31:16] > 16'h7F80 |=> o_result[31:24] == 8'hFF;
  endproperty
  a_sat_high_first: assert property (p_sat_high_first) else $error("first upper clamp wrong");

  property p_sat_no_flag;
    is_sat_w && !i_first_src[31] && !i_first_src[15] && !i_second_src[31] && !i_second_src[15] &&
      i_first_src[31:16] <= 16'h7F80 && i_first_src[15:0] <= 16'h7F80 &&
      i_second_src[31:16] <= 16'h7F80 && i_second_src[15:0] <= 16'h7F80
      |=> !o_ctrl_we;
  endproperty
  a_sat_no_flag: assert property (p_sat_no_flag) else $error("byte flag without clamp");

endmodule // dspcv_unit

// *** tb/dspcv_partner.sv ***
// Decode stage and register file on the far side of the unit
module dspcv_partner (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [31:0] i_req_instr,
  input wire logic i_result_valid,
  input wire logic [31:0] i_result,
  input wire logic [4:0] i_dest_idx,
  input wire logic i_ctrl_we,
  input wire logic [31:0] i_ctrl_value,
  output logic o_issue_valid,
  output logic [31:0] o_instr,
  output logic [31:0] o_first_src,
  output logic [31:0] o_second_src,
  output logic [31:0] o_dsp_control
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] regs [32];
  logic [31:0] ctrl_reg;
  assign o_issue_valid = i_req;
  assign o_instr = i_req_instr;
  assign o_first_src = regs[i_req_instr[25:21]];
  assign o_second_src = regs[i_req_instr[20:16]];
  // Forward a flag written this edge so a back-to-back issue sees it
  assign o_dsp_control = i_ctrl_we ? i_ctrl_value : ctrl_reg;
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      ctrl_reg <= 32'h0000_0000;
    end else begin
      if (i_result_valid) begin
        regs[i_dest_idx] <= i_result;
      end
      if (i_ctrl_we) begin
        ctrl_reg <= i_ctrl_value;
      end
    end
  end
endmodule // dspcv_partner

// *** tb/dspcv_unit_tb.sv ***
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module dspcv_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dspcv_pkg::*;
  logic i_clock, i_rst_n, req, rv, cwe, unk, iv;
  logic [31:0] rinstr, ins, fs, ss, dc, res, cval;
  logic [4:0] didx;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] op_ins [4], op_a [4], op_b [4], exp_ctrl;
  dspcv_partner partner (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(req), .i_req_instr(rinstr),
    .i_result_valid(rv), .i_result(res), .i_dest_idx(didx), .i_ctrl_we(cwe), .i_ctrl_value(cval),
    .o_issue_valid(iv), .o_instr(ins), .o_first_src(fs), .o_second_src(ss), .o_dsp_control(dc));
  dspcv_unit dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_issue_valid(iv), .i_instr(ins),
    .i_first_src(fs), .i_second_src(ss), .i_dsp_control(dc), .o_result_valid(rv), .o_result(res),
    .o_dest_idx(didx), .o_ctrl_we(cwe), .o_ctrl_value(cval), .o_unknown(unk));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Reference model worked out independently of the design
  function automatic logic cl(logic [15:0] h);
    return h[15] | (h > 16'h7F80);
  endfunction
  function automatic logic [7:0] sb(logic [15:0] h);
    return h[15] ? 8'h00 : (h > 16'h7F80) ? 8'hFF : h[14:7];
  endfunction
  function automatic logic [33:0] model(logic [31:0] i, logic [31:0] a, logic [31:0] b);
    logic [32:0] s1, s2;
    logic o1, o2;
    s1 = {a[31], a} + 33'h0_0000_8000;
    s2 = {b[31], b} + 33'h0_0000_8000;
    o1 = s1[32] ^ s1[31];
    o2 = s2[32] ^ s2[31];
    if (i[31:26] !== EXTENSION_MAJOR_OPCODE) return {2'b10, 32'h0000_0000};
    case ({i[10:6], i[5:0]})
      {5'h1F, 6'h12}: return {2'b00, 8'h00, b[23:16], 8'h00, b[7:0]};
      {5'h14, 6'h11}: return {2'b00, a[31:16], b[31:16]};
      {5'h0C, 6'h11}: return {2'b00, a[31:24], a[15:8], b[31:24], b[15:8]};
      {5'h15, 6'h11}: return {1'b0, o1 | o2, o1 ? 16'h7FFF : s1[31:16], o2 ? 16'h7FFF : s2[31:16]};
      {5'h0F, 6'h11}: return {1'b0, cl(a[31:16]) | cl(a[15:0]) | cl(b[31:16]) | cl(b[15:0]),
        sb(a[31:16]), sb(a[15:0]), sb(b[31:16]), sb(b[15:0])};
      default: return {2'b10, 32'h0000_0000};
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Shared issue and compare; ops issue back to back, one per cycle
  task automatic set_op(int k, logic [5:0] mj, logic [4:0] sub, logic [5:0] fn, logic [31:0] a, logic [31:0] b);
    op_ins[k] = {mj, 5'(2 * k + 1), 5'(2 * k + 2), 5'(20 + k), sub, fn};
    op_a[k] = a;
    op_b[k] = b;
  endtask
  task automatic run_ops(int n);
    logic [33:0] e;
    for (int k = 0; k < n; k++) begin
      partner.regs[2 * k + 1] = op_a[k];
      partner.regs[2 * k + 2] = op_b[k];
      rinstr = op_ins[k];
      req = 1'b1;
      @(posedge i_clock);
      #10;
      e = model(op_ins[k], op_a[k], op_b[k]);
      `CHK(unk, e[33])
      `CHK(rv, ~e[33])
      `CHK(cwe, e[32])
      if (!e[33]) `CHK(res, e[31:0])
      if (!e[33]) `CHK(didx, op_ins[k][15:11])
      if (e[32]) `CHK(cval, exp_ctrl | OUFLAG_SAT_MASK)
      if (e[32]) exp_ctrl = exp_ctrl | OUFLAG_SAT_MASK;
    end
    req = 1'b0;
    @(posedge i_clock);
    #10;
    `CHK(partner.ctrl_reg, exp_ctrl)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_expand_and_trunc;
    set_op(0, 6'h1F, 5'h1F, 6'h12, 32'hFFFF_FFFF, 32'hA1B2_C3D4);
    set_op(1, 6'h1F, 5'h14, 6'h11, 32'h1234_5678, 32'h9ABC_DEF0);
    set_op(2, 6'h1F, 5'h0C, 6'h11, 32'h1234_5678, 32'h9ABC_DEF0);
    run_ops(3);
  endtask
  task automatic t_round;
    set_op(0, 6'h1F, 5'h15, 6'h11, 32'h8000_0000, 32'h1234_8000);
    set_op(1, 6'h1F, 5'h15, 6'h11, 32'h7FFF_8000, 32'h0001_7FFF);
    set_op(2, 6'h1F, 5'h15, 6'h11, 32'h0001_7FFF, 32'h7FFF_FFFF);
    run_ops(3);
  endtask
  task automatic t_sat_ubytes;
    set_op(0, 6'h1F, 5'h0F, 6'h11, 32'h7F80_0100, 32'h0080_0000);
    set_op(1, 6'h1F, 5'h0F, 6'h11, 32'h8000_7F80, 32'h7F81_0123);
    set_op(2, 6'h1F, 5'h0F, 6'h11, 32'h7FFF_7F81, 32'h0000_7FC0);
    set_op(3, 6'h1F, 5'h0F, 6'h11, 32'h0000_0000, 32'h0000_FFFF);
    run_ops(4);
  endtask
  task automatic t_keep_ctrl_bits;
    partner.ctrl_reg = 32'h0F00_00A5;
    exp_ctrl = 32'h0F00_00A5;
    set_op(0, 6'h1F, 5'h15, 6'h11, 32'h0000_0000, 32'h0000_0000);
    set_op(1, 6'h1F, 5'h15, 6'h11, 32'h7FFF_FFFF, 32'h0000_0000);
    set_op(2, 6'h1F, 5'h0F, 6'h11, 32'hFFFF_FFFF, 32'h0000_0000);
    run_ops(3);
  endtask
  task automatic t_unhandled;
    set_op(0, 6'h1F, 5'h00, 6'h11, 32'h7FFF_8000, 32'h8000_0000);
    set_op(1, 6'h1E, 5'h15, 6'h11, 32'h7FFF_8000, 32'h8000_0000);
    set_op(2, 6'h1F, 5'h15, 6'h12, 32'h7FFF_8000, 32'h8000_0000);
    set_op(3, 6'h1F, 5'h1F, 6'h11, 32'h7FFF_8000, 32'h8000_0000);
    run_ops(4);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    // Tests need well under 100 cycles; the margin is generous
    #(2000 * 100);
    fails++;
    give_verdict();
  end
  initial begin
    i_rst_n = 1'b0;
    req = 1'b0;
    rinstr = 32'h0000_0000;
    exp_ctrl = 32'h0000_0000;
    for (int r = 0; r < 32; r++) partner.regs[r] = 32'h0000_0000;
    repeat (2) @(posedge i_clock);
    #10;
    `CHK(rv, 1'b0)
    i_rst_n = 1'b1;
    t_expand_and_trunc();
    t_round();
    t_sat_ubytes();
    t_keep_ctrl_bits();
    t_unhandled();
    give_verdict();
  end
endmodule // dspcv_unit_tb
